// >>> design/step_select_defs.svh
// step_select_defs.svh: selection codes and block codes of one logic step
// assumes: included by the package and the step modules, definitions only
`ifndef STEP_SELECT_DEFS_SVH
`define STEP_SELECT_DEFS_SVH

`define SEL_W 14
`define GP_FIRST 14'd0
`define GP_LAST 14'd105
`define GP_UNIVERSAL_DO 14'd27
`define GP_LOGIC_OUT_FIRST 14'd111
`define GP_LOGIC_OUT_LAST 14'd120
`define NEG_OFFSET 14'd1000
`define STEP_FIRST 14'd2001
`define STEP_LAST 14'd2200
`define STEP_COUNT 200
`define TERM_GEN_FIRST 14'd4001
`define TERM_GEN_LAST 14'd4005
`define TERM_FWD 14'd4010
`define TERM_REV 14'd4011
`define TERM_OPT_FIRST 14'd4021
`define TERM_OPT_LAST 14'd4033
`define STAT_FIRST 14'd6000
`define STAT_LAST 14'd6006
`define STAT_ALARM 14'd6007
`define BAND_STEP 14'd2000
`define BAND_TERM 14'd4000
`define BAND_STAT 14'd6000
`define BAND_TOP 14'd8000
`define GP_COUNT 106
`define GEN_TERM_COUNT 5
`define OPT_TERM_COUNT 13
`define STAT_COUNT 7
`define BLOCK_W 8
`define BLOCK_SETP_FIRST 8'd50
`define BLOCK_SETP_LAST 8'd55
`define BLOCK_RSTP_FIRST 8'd60
`define BLOCK_RSTP_LAST 8'd65
`define OUT_RESET 1'b0

`endif

// >>> design/step_select_pkg.sv
// step_select_pkg: types shared by the logic step modules
// assumes: step_select_defs.svh is on the include path
package step_select_pkg;
`include "step_select_defs.svh"

    typedef logic [`SEL_W-1:0] sel_code_t;

    typedef enum logic [1:0] {
        FF_NONE,
        FF_SET_PRIO,
        FF_RESET_PRIO
    } ff_mode_e;

    // the pool of signals a step input may choose from
    typedef struct packed {
        logic [`GP_COUNT-1:0] gp_out;
        logic [`STEP_COUNT-1:0] step_out;
        logic [`GEN_TERM_COUNT-1:0] gen_term;
        logic fwd_term;
        logic rev_term;
        logic [`OPT_TERM_COUNT-1:0] opt_term;
        logic [`STAT_COUNT-1:0] status;
        logic alarm_present;
    } signal_pool_s;

    typedef struct packed {
        logic in_one;
        logic in_two;
        logic out;
        ff_mode_e mode;
        logic mode_ok;
    } step_state_s;

endpackage : step_select_pkg

// >>> design/step_input_mux.sv
// step_input_mux: picks one pool signal from a selection code
// assumes: pool sampled on sys_clk, code held static between edits
`timescale 1ns/100ps
`include "step_select_defs.svh"
module step_input_mux
    import step_select_pkg::*;
(
    input wire signal_pool_s pool,
    input wire sel_code_t code,
    output logic sel_bit
);
    sel_code_t base;
    logic neg;
    logic raw;
    logic [`SEL_W-1:0] idx;

    always_comb begin
        neg = 1'b0;
        base = code;
        // the whole odd thousand of every band is the twin, so undefined twins read ON
        if ((code >= `NEG_OFFSET && code < `BAND_STEP)
            || (code >= `BAND_STEP + `NEG_OFFSET && code < `BAND_TERM)
            || (code >= `BAND_TERM + `NEG_OFFSET && code < `BAND_STAT)
            || (code >= `BAND_STAT + `NEG_OFFSET && code < `BAND_TOP)) begin
            neg = 1'b1;
            base = code - `NEG_OFFSET;
        end
        raw = 1'b0; // unknown codes read OFF unless in an odd thousand below 8000
        idx = '0;
        if (base <= `GP_LAST) begin
            if (base != `GP_UNIVERSAL_DO) begin
                raw = pool.gp_out[base[6:0]];
            end
        end else if (base >= `STEP_FIRST && base <= `STEP_LAST) begin
            idx = base - `STEP_FIRST;
            raw = pool.step_out[idx[7:0]];
        end else if (base >= `TERM_GEN_FIRST && base <= `TERM_GEN_LAST) begin
            idx = base - `TERM_GEN_FIRST;
            raw = pool.gen_term[idx[2:0]];
        end else if (base == `TERM_FWD) begin
            raw = pool.fwd_term;
        end else if (base == `TERM_REV) begin
            raw = pool.rev_term;
        end else if (base >= `TERM_OPT_FIRST && base <= `TERM_OPT_LAST) begin
            idx = base - `TERM_OPT_FIRST;
            raw = pool.opt_term[idx[3:0]];
        end else if (base >= `STAT_FIRST && base <= `STAT_LAST) begin
            idx = base - `STAT_FIRST;
            raw = pool.status[idx[2:0]];
        end else if (base == `STAT_ALARM) begin
            raw = ~pool.alarm_present;
        end else if (base >= `GP_LOGIC_OUT_FIRST && base <= `GP_LOGIC_OUT_LAST) begin
            raw = 1'b0;
        end
        // codes 106..110 have no signal behind them and stay OFF
        sel_bit = raw ^ neg;
    end
endmodule : step_input_mux

// >>> design/custom_logic_step_select.sv
// custom_logic_step_select: one flip-flop step of the customizable logic
// assumes: task_tick pulses once per task cycle, synchronous to sys_clk
`timescale 1ns/100ps
`include "step_select_defs.svh"

// What this block does
// - set priority: input one wins, else input two resets, else hold
// - reset priority: input two wins, else input one sets, else hold
// - low codes pick general drive outputs
// - code plus 1000 gives inverted signal
// - universal digital output code not selectable
// - logic output codes 111..120 not selectable
// - codes 2001..2200 pick step outputs
// - terminal codes pick terminals and option inputs
// - status codes pick run and state flags
// - alarm code reads ON with no alarm
// - block codes 50..55/60..65 pick flip-flop modes
module custom_logic_step_select
    import step_select_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic task_tick,
    input wire logic [`BLOCK_W-1:0] block_select,
    input wire sel_code_t input_one_select,
    input wire sel_code_t input_two_select,
    input wire signal_pool_s pool,
    output logic step_out,
    output logic in_one_seen,
    output logic in_two_seen,
    output logic mode_valid
);
    step_state_s state_r;
    step_state_s state_nxt;
    logic sel_one;
    logic sel_two;

    step_input_mux u_mux_one (
        .pool(pool),
        .code(input_one_select),
        .sel_bit(sel_one)
    );

    step_input_mux u_mux_two (
        .pool(pool),
        .code(input_two_select),
        .sel_bit(sel_two)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        state_nxt = state_r;
        if (block_select >= `BLOCK_SETP_FIRST && block_select <= `BLOCK_SETP_LAST) begin
            state_nxt.mode = FF_SET_PRIO;
            state_nxt.mode_ok = 1'b1;
        end else if (block_select >= `BLOCK_RSTP_FIRST
                     && block_select <= `BLOCK_RSTP_LAST) begin
            state_nxt.mode = FF_RESET_PRIO;
            state_nxt.mode_ok = 1'b1;
        end else begin
            state_nxt.mode = FF_NONE;
            state_nxt.mode_ok = 1'b0;
        end
        if (task_tick) begin
            state_nxt.in_one = sel_one;
            state_nxt.in_two = sel_two;
            unique case (state_nxt.mode)
                FF_SET_PRIO: begin
                    if (sel_one) begin
                        state_nxt.out = 1'b1;
                    end else if (sel_two) begin
                        state_nxt.out = 1'b0;
                    end
                end
                FF_RESET_PRIO: begin
                    if (sel_two) begin
                        state_nxt.out = 1'b0;
                    end else if (sel_one) begin
                        state_nxt.out = 1'b1;
                    end
                end
                FF_NONE: begin
                    state_nxt.out = `OUT_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= '{in_one: 1'b0, in_two: 1'b0, out: `OUT_RESET, mode: FF_NONE,
                         mode_ok: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign step_out = state_r.out;
    assign in_one_seen = state_r.in_one;
    assign in_two_seen = state_r.in_two;
    assign mode_valid = state_r.mode_ok;

endmodule : custom_logic_step_select

// >>> verification/step_select_properties.sv
// step_select_properties: checks on one flip-flop logic step
// assumes: one clock, bound to custom_logic_step_select
`timescale 1ns/100ps
`include "step_select_defs.svh"
module step_select_properties
    import step_select_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic task_tick,
    input wire logic [`BLOCK_W-1:0] block_select,
    input wire sel_code_t input_one_select,
    input wire sel_code_t input_two_select,
    input wire signal_pool_s pool,
    input wire logic step_out,
    input wire logic in_one_seen,
    input wire logic in_two_seen,
    input wire logic mode_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic setp = block_select inside {[50:55]};
    wire logic rstp = block_select inside {[60:65]};
    AST_SETP: assert property (task_tick && setp |=>
        (in_one_seen ? step_out : (in_two_seen ? !step_out : 1'b1))) else $error("set prio");
    AST_RSTP: assert property (task_tick && rstp |=>
        (in_two_seen ? !step_out : (in_one_seen ? step_out : 1'b1))) else $error("reset prio");
    AST_HOLD: assert property (task_tick && (setp || rstp) |=>
        (in_one_seen || in_two_seen || step_out == $past(step_out))) else $error("hold");
    AST_NONFF: assert property (task_tick && !setp && !rstp |=> !step_out)
        else $error("no function");
    AST_TICK: assert property (!task_tick |=>
        $stable({step_out, in_one_seen, in_two_seen})) else $error("no tick");
    AST_MODE: assert property (1'b1 |=> mode_valid == $past(setp || rstp))
        else $error("mode");
    AST_ALARM: assert property (task_tick && input_one_select == `STAT_ALARM |=>
        in_one_seen == !$past(pool.alarm_present)) else $error("alarm");
    AST_TERM: assert property (task_tick && input_two_select == `TERM_FWD |=>
        in_two_seen == $past(pool.fwd_term)) else $error("fwd");
    cover property (task_tick && setp);
    cover property (task_tick && rstp);
    cover property (task_tick && input_one_select == `STAT_ALARM);
endmodule : step_select_properties
bind custom_logic_step_select step_select_properties chk (.sys_clk, .rstn, .task_tick,
    .block_select, .input_one_select, .input_two_select, .pool, .step_out, .in_one_seen,
    .in_two_seen, .mode_valid);

// >>> verification/pool_model.sv
// pool_model: terminals, flags and other steps feeding the pool
// assumes: the bench refreshes noise every clock
`timescale 1ns/100ps
module pool_model
    import step_select_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [31:0] noise,
    output signal_pool_s pool
);
    wire logic [351:0] wide = {11{noise}};
    always_ff @(posedge sys_clk) begin
        pool <= wide[334:0];
    end
endmodule : pool_model

// >>> verification/tb_top.sv
// tb_top: random ticks, modes and selection codes against a bench model
// assumes: pool_model stands for the far side
`timescale 1ns/100ps
module tb_top
    import step_select_pkg::*;
;
    logic sys_clk = 0, rstn = 0, task_tick = 0, step_out, in_one_seen, in_two_seen, mode_valid;
    logic [7:0] block_select = 0;
    sel_code_t input_one_select = 0, input_two_select = 0;
    logic [31:0] noise = 0;
    signal_pool_s pool;
    logic e_out = 0, e1 = 0, e2 = 0, e_mv = 0;
    int seed = 70, num_errors = 0, checks = 0;
    int lo[7] = '{0, 2001, 4001, 4010, 4021, 6000, 106};
    int n[7] = '{106, 200, 5, 2, 13, 8, 15};
    always #5 sys_clk = ~sys_clk;
    pool_model pm (.sys_clk, .noise, .pool);
    custom_logic_step_select uut (.sys_clk, .rstn, .task_tick, .block_select,
        .input_one_select, .input_two_select, .pool, .step_out, .in_one_seen, .in_two_seen,
        .mode_valid);
    function automatic logic pick(signal_pool_s p, int c);
        int b = (c / 1000) % 2 ? c - 1000 : c;
        logic v = 0;
        if (b <= 105 && b != 27) v = p.gp_out[b];
        else if (b >= 2001 && b <= 2200) v = p.step_out[b-2001];
        else if (b >= 4001 && b <= 4005) v = p.gen_term[b-4001];
        else if (b == 4010) v = p.fwd_term;
        else if (b == 4011) v = p.rev_term;
        else if (b >= 4021 && b <= 4033) v = p.opt_term[b-4021];
        else if (b >= 6000 && b <= 6006) v = p.status[b-6000];
        else if (b == 6007) v = !p.alarm_present;
        return v ^ ((c / 1000) % 2 == 1);
    endfunction : pick
    function automatic sel_code_t code();
        int r = {$random(seed)} % 7;
        return sel_code_t'(lo[r] + {$random(seed)} % n[r] + ($random(seed) & 1) * 1000);
    endfunction : code
    task chk(string nm, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk
    task close_out();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1;
        for (int i = 0; i < 2000; i++) begin
            @(posedge sys_clk);
            chk("step_out", e_out, step_out);
            chk("in_one_seen", e1, in_one_seen);
            chk("in_two_seen", e2, in_two_seen);
            chk("mode_valid", e_mv, mode_valid);
            e_mv = block_select inside {[50:55], [60:65]};
            if (task_tick) begin
                e1 = pick(pool, input_one_select);
                e2 = pick(pool, input_two_select);
                if (block_select inside {[50:55]}) e_out = e1 | (!e2 & e_out);
                else if (block_select inside {[60:65]}) e_out = !e2 & (e1 | e_out);
                else e_out = 0;
            end
            // a short reset in mid-run clears every output at once
            if (!rstn || (i >= 1000 && i < 1004)) begin
                e_out = 0;
                e1 = 0;
                e2 = 0;
                e_mv = 0;
            end
            rstn <= !(i >= 1000 && i < 1004);
            // first ticks back to back, first codes on the excluded output
            task_tick <= i < 8 || ($random(seed) & 1);
            block_select <= {$random(seed)} % 80;
            input_one_select <= i < 2 ? 14'd27 : code();
            input_two_select <= code();
            noise <= $random(seed);
        end
        close_out();
    end
endmodule : tb_top
